// file: design/mcuex_alu_if.sv
// Interface: operands and results between the core and its subtractor
`timescale 1ns/1ps
`default_nettype none

interface mcuex_alu_if;
  import mcuex_pkg::*;

  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic borrowIn;
  logic [7:0] diff;
  logic carryOut;
  logic halfCarry;
  logic wrap;

  modport core (output minuend, output subtrahend, output borrowIn,
                input diff, input carryOut, input halfCarry, input wrap);
  modport alu (input minuend, input subtrahend, input borrowIn,
               output diff, output carryOut, output halfCarry, output wrap);
endinterface

`default_nettype wire

// file: design/mcuex_exec.sv
// Execution unit for rotate, subtract, skip, set, swap, table read and XOR
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module mcuex_exec
  import mcuex_pkg::*;
(
  input wire logic clk, // 50 MHz instruction clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clkEn, // Freezes all state while low, except that a low reset_n still resets it
  input wire logic issueValid, // Instruction presented this cycle
  output logic issueReady, // Unit can take an instruction
  input wire mcuex_op_t issueOp, // Operation code
  input wire logic [7:0] memOperand, // Data memory operand value
  input wire logic [7:0] literal, // Immediate value from instruction
  input wire logic [2:0] bitIndex, // Bit select for bit forms
  input wire logic [15:0] progWord, // Program word at table pointer
  output logic [15:0] tablePointer, // Table pointer high and low bytes
  input wire logic [7:0] tablePointerLow, // Table pointer low byte
  input wire logic [7:0] tablePointerHigh, // Table pointer high byte
  output logic memWrite, // Write strobe for data memory
  output logic [7:0] memWriteData, // Data written to memory
  output logic [7:0] workingRegister, // Working register value
  output logic [5:0] statusFlags, // OV, Z, AC, C, SC, CZ flags
  output logic [7:0] tableReadHighByte, // High byte from table read
  output logic squashNext, // Next fetched instruction is squashed
  output logic busy // Dummy cycle of a taken skip
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {
    MCUEX_ST_RUN,
    MCUEX_ST_DUMMY
  } mcuex_phase_t;

  typedef struct packed {
    mcuex_phase_t phase;
    logic [7:0] work;
    logic [5:0] flags;
    logic [7:0] table_read_high_byte;
    logic memWr;
    logic [7:0] memData;
    logic squash;
  } mcuex_state_t;

  mcuex_state_t state_q;
  mcuex_state_t state_d;

  mcuex_alu_if subBus ();

  mcuex_subtractor mcuex_subtractor_inst (
    .sub(subBus.alu)
  );

  function automatic logic [7:0] swapNib(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  function automatic logic isZero(input logic [7:0] v);
    return (v == ZERO_BYTE);
  endfunction

  logic [7:0] decVal;
  logic [7:0] incVal;
  logic selBit;
  logic subSel;
  logic subToMem;
  logic skipTake;
  logic take;

  // ----------------------------------------------------------------
  // Operand selection for the subtractor
  // ----------------------------------------------------------------
  always_comb begin
    subBus.minuend = state_q.work;
    subBus.subtrahend = memOperand;
    subBus.borrowIn = 1'b0;
    case (issueOp)
      MCUEX_OP_SUBB_W, MCUEX_OP_SUBB_MEM: begin
        subBus.borrowIn = ~state_q.flags[FLAG_C];
      end
      MCUEX_OP_SUBB_IMM: begin
        subBus.subtrahend = literal;
        subBus.borrowIn = ~state_q.flags[FLAG_C];
      end
      MCUEX_OP_MINUS_IMM: begin
        subBus.subtrahend = literal;
      end
      default: begin
        subBus.borrowIn = 1'b0;
      end
    endcase
  end

  assign decVal = memOperand - ONE_BYTE;
  assign incVal = memOperand + ONE_BYTE;
  assign selBit = memOperand[bitIndex];
  assign issueReady = (state_q.phase == MCUEX_ST_RUN);
  assign take = issueValid && issueReady;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.memWr = 1'b0;
    state_d.squash = 1'b0;
    subSel = 1'b0;
    subToMem = 1'b0;
    skipTake = 1'b0;
    case (state_q.phase)
      MCUEX_ST_DUMMY: begin
        state_d.phase = MCUEX_ST_RUN;
      end
      MCUEX_ST_RUN: begin
        if (take) begin
          case (issueOp)
            MCUEX_OP_ROTR_CARRY_W: begin
              state_d.work = {state_q.flags[FLAG_C], memOperand[7:1]};
              state_d.flags[FLAG_C] = memOperand[0];
            end
            MCUEX_OP_SUBB_W, MCUEX_OP_SUBB_IMM, MCUEX_OP_MINUS_W, MCUEX_OP_MINUS_IMM: begin
              subSel = 1'b1;
            end
            MCUEX_OP_SUBB_MEM, MCUEX_OP_MINUS_MEM: begin
              subSel = 1'b1;
              subToMem = 1'b1;
            end
            MCUEX_OP_DEC_SKZ: begin
              state_d.memWr = 1'b1;
              state_d.memData = decVal;
              skipTake = isZero(decVal);
            end
            MCUEX_OP_DEC_SKZ_COPY: begin
              state_d.work = decVal;
              skipTake = isZero(decVal);
            end
            MCUEX_OP_INC_SKZ: begin
              state_d.memWr = 1'b1;
              state_d.memData = incVal;
              skipTake = isZero(incVal);
            end
            MCUEX_OP_INC_SKZ_COPY: begin
              state_d.work = incVal;
              skipTake = isZero(incVal);
            end
            MCUEX_OP_SET_BYTE: begin
              state_d.memWr = 1'b1;
              state_d.memData = ALL_ONES;
            end
            MCUEX_OP_SET_BIT: begin
              state_d.memWr = 1'b1;
              state_d.memData = memOperand | (ONE_BYTE << bitIndex);
            end
            MCUEX_OP_SKNZ_BIT: begin
              skipTake = selBit;
            end
            MCUEX_OP_SKZ_BIT: begin
              skipTake = ~selBit;
            end
            MCUEX_OP_SKNZ_BYTE: begin
              state_d.memWr = 1'b1;
              state_d.memData = memOperand;
              skipTake = ~isZero(memOperand);
            end
            MCUEX_OP_SKZ_BYTE: begin
              state_d.memWr = 1'b1;
              state_d.memData = memOperand;
              skipTake = isZero(memOperand);
            end
            MCUEX_OP_COPY_SKZ: begin
              state_d.work = memOperand;
              skipTake = isZero(memOperand);
            end
            MCUEX_OP_SWAP_MEM: begin
              state_d.memWr = 1'b1;
              state_d.memData = swapNib(memOperand);
            end
            MCUEX_OP_SWAP_W: begin
              state_d.work = swapNib(memOperand);
            end
            MCUEX_OP_TABLE_READ: begin
              state_d.memWr = 1'b1;
              state_d.memData = progWord[7:0];
              state_d.table_read_high_byte = progWord[15:8];
            end
            MCUEX_OP_XOR_W: begin
              state_d.work = state_q.work ^ memOperand;
              state_d.flags[FLAG_Z] = isZero(state_q.work ^ memOperand);
            end
            MCUEX_OP_XOR_IMM: begin
              state_d.work = state_q.work ^ literal;
              state_d.flags[FLAG_Z] = isZero(state_q.work ^ literal);
            end
            MCUEX_OP_XOR_MEM: begin
              state_d.memWr = 1'b1;
              state_d.memData = state_q.work ^ memOperand;
              state_d.flags[FLAG_Z] = isZero(state_q.work ^ memOperand);
            end
            default: begin
              state_d.memWr = 1'b0;
            end
          endcase
          if (subSel) begin
            if (subToMem) begin
              state_d.memWr = 1'b1;
              state_d.memData = subBus.diff;
            end else begin
              state_d.work = subBus.diff;
            end
            state_d.flags[FLAG_C] = subBus.carryOut;
            state_d.flags[FLAG_AC] = subBus.halfCarry;
            state_d.flags[FLAG_OV] = subBus.wrap;
            state_d.flags[FLAG_Z] = isZero(subBus.diff);
            state_d.flags[FLAG_SC] = subBus.wrap ^ subBus.diff[7];
            state_d.flags[FLAG_CZ] = isZero(subBus.diff);
          end
          if (skipTake) begin
            state_d.squash = 1'b1;
            state_d.phase = MCUEX_ST_DUMMY;
          end
        end
      end
      default: begin
        state_d.phase = MCUEX_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q.phase <= MCUEX_ST_RUN;
      state_q.work <= WORK_RST;
      state_q.flags <= FLAGS_RST;
      state_q.table_read_high_byte <= TABLE_READ_HIGH_BYTE_RST;
      state_q.memWr <= 1'b0;
      state_q.memData <= ZERO_BYTE;
      state_q.squash <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tablePointer = {tablePointerHigh, tablePointerLow};
  assign memWrite = state_q.memWr;
  assign memWriteData = state_q.memData;
  assign workingRegister = state_q.work;
  assign statusFlags = state_q.flags;
  assign tableReadHighByte = state_q.table_read_high_byte;
  assign squashNext = state_q.squash;
  assign busy = (state_q.phase == MCUEX_ST_DUMMY);

endmodule

`default_nettype wire

// file: design/mcuex_pkg.sv
// Package: opcodes, flag positions, reset values and widths for the execution block
package mcuex_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PROG_W = 16;
  localparam int unsigned TPTR_W = 16;

  // ----------------------------------------------------------------
  // Status flag bit positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_AC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_SC = 4;
  localparam int unsigned FLAG_CZ = 5;
  localparam int unsigned FLAG_W = 6;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] TABLE_READ_HIGH_BYTE_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MCUEX_OP_NONE,
    MCUEX_OP_ROTR_CARRY_W,
    MCUEX_OP_SUBB_W,
    MCUEX_OP_SUBB_IMM,
    MCUEX_OP_SUBB_MEM,
    MCUEX_OP_MINUS_W,
    MCUEX_OP_MINUS_IMM,
    MCUEX_OP_MINUS_MEM,
    MCUEX_OP_DEC_SKZ,
    MCUEX_OP_DEC_SKZ_COPY,
    MCUEX_OP_INC_SKZ,
    MCUEX_OP_INC_SKZ_COPY,
    MCUEX_OP_SET_BYTE,
    MCUEX_OP_SET_BIT,
    MCUEX_OP_SKNZ_BIT,
    MCUEX_OP_SKZ_BIT,
    MCUEX_OP_SKNZ_BYTE,
    MCUEX_OP_SKZ_BYTE,
    MCUEX_OP_COPY_SKZ,
    MCUEX_OP_SWAP_MEM,
    MCUEX_OP_SWAP_W,
    MCUEX_OP_TABLE_READ,
    MCUEX_OP_XOR_W,
    MCUEX_OP_XOR_IMM,
    MCUEX_OP_XOR_MEM
  } mcuex_op_t;

endpackage

// file: design/mcuex_subtractor.sv
// Eight-bit subtractor with borrow, half-borrow and signed wrap outputs
`timescale 1ns/1ps
`default_nettype none

module mcuex_subtractor
  import mcuex_pkg::*;
(
  mcuex_alu_if.alu sub // Operand and result bundle
);

  logic [4:0] lowNib;
  logic [8:0] full;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    lowNib = {1'b0, sub.minuend[3:0]} - {1'b0, sub.subtrahend[3:0]} - {4'h0, sub.borrowIn};
    full = {1'b0, sub.minuend} - {1'b0, sub.subtrahend} - {8'h00, sub.borrowIn};
    sub.diff = full[7:0];
    // Carry set when no borrow, cleared when the subtraction borrows out of bit 7
    sub.carryOut = ~full[8];
    sub.halfCarry = ~lowNib[4];
    sub.wrap = (sub.minuend[7] != sub.subtrahend[7]) && (full[7] != sub.minuend[7]);
  end

endmodule

`default_nettype wire

// file: tb/mcuex_exec_assertions.sv
// Checker: timing and result properties of the execution block
`timescale 1ns/1ps
`default_nettype none

module mcuex_exec_assertions
  import mcuex_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic clkEn, // Advance
  input wire logic issueValid, // Request
  input wire logic issueReady, // Ready
  input wire mcuex_op_t issueOp, // Opcode
  input wire logic [7:0] memOperand, // Operand
  input wire logic [2:0] bitIndex, // Bit select
  input wire logic [15:0] progWord, // Program word
  input wire logic [15:0] tablePointer, // Pointer out
  input wire logic [7:0] tablePointerLow, // Pointer low
  input wire logic [7:0] tablePointerHigh, // Pointer high
  input wire logic memWrite, // Write strobe
  input wire logic [7:0] memWriteData, // Write data
  input wire logic [7:0] workingRegister, // Working value
  input wire logic [5:0] statusFlags, // Flags
  input wire logic [7:0] tableReadHighByte, // Table high
  input wire logic squashNext, // Squash
  input wire logic busy // Dummy cycle
);
  logic take;
  assign take = issueValid && issueReady && clkEn;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_READY: assert property (issueReady == !busy)
    else $error("ready is not the inverse of busy");
  AST_BUSY_ONE: assert property (busy && clkEn |=> !busy && issueReady)
    else $error("dummy cycle longer than one cycle");
  AST_SQUASH: assert property (squashNext |-> busy)
    else $error("squash without dummy cycle");
  AST_DUMMY_IDLE: assert property (busy && clkEn |=> !memWrite && !squashNext)
    else $error("dummy cycle did work");
  AST_SKIP_CAUSE: assert property ($rose(busy) |-> $past(take))
    else $error("dummy cycle without an instruction");
  AST_DEC_SKIP: assert property (take && issueOp == MCUEX_OP_DEC_SKZ |=> memWrite
    && memWriteData == $past(memOperand) - 8'h01 && busy == (memWriteData == 8'h00))
    else $error("decrement and skip wrong");
  AST_SET_BYTE: assert property (take && issueOp == MCUEX_OP_SET_BYTE |=> memWrite
    && memWriteData == 8'hFF && statusFlags == $past(statusFlags))
    else $error("byte set wrong");
  AST_SET_BIT: assert property (take && issueOp == MCUEX_OP_SET_BIT |=> memWrite
    && memWriteData == ($past(memOperand) | (8'h01 << $past(bitIndex))))
    else $error("bit set wrong");
  AST_SWAP_W: assert property (take && issueOp == MCUEX_OP_SWAP_W |=> !memWrite
    && workingRegister == {$past(memOperand[3:0]), $past(memOperand[7:4])})
    else $error("nibble swap to working wrong");
  AST_TABLE: assert property (take && issueOp == MCUEX_OP_TABLE_READ |=>
    memWriteData == $past(progWord[7:0]) && tableReadHighByte == $past(progWord[15:8]))
    else $error("table read wrong");
  AST_TPTR: assert property (tablePointer == {tablePointerHigh, tablePointerLow})
    else $error("table pointer wrong");
  AST_ROTR: assert property (take && issueOp == MCUEX_OP_ROTR_CARRY_W |=>
    workingRegister == {$past(statusFlags[0]), $past(memOperand[7:1])}
    && statusFlags[0] == $past(memOperand[0]) && !memWrite)
    else $error("rotate through carry wrong");
endmodule

bind mcuex_exec mcuex_exec_assertions mcuex_exec_assertions_inst (
  .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .issueValid(issueValid),
  .issueReady(issueReady), .issueOp(issueOp), .memOperand(memOperand),
  .bitIndex(bitIndex), .progWord(progWord), .tablePointer(tablePointer),
  .tablePointerLow(tablePointerLow), .tablePointerHigh(tablePointerHigh),
  .memWrite(memWrite), .memWriteData(memWriteData), .workingRegister(workingRegister),
  .statusFlags(statusFlags), .tableReadHighByte(tableReadHighByte),
  .squashNext(squashNext), .busy(busy)
);

`default_nettype wire

// file: tb/mcuex_exec_tb.sv
// Testbench: random and directed instructions against a reference model
`timescale 1ns/1ps
`default_nettype none

module mcuex_exec_tb;
  import mcuex_pkg::*;
  logic clk = 0, reset_n = 0, clkEn = 1, issueValid = 0;
  mcuex_op_t issueOp = MCUEX_OP_NONE;
  logic [7:0] memOperand = 8'h00, literal = 8'h00, tpLo = 8'h00, tpHi = 8'h00;
  logic [2:0] bitIndex = 3'h0;
  logic [15:0] progWord = 16'h0000, tablePointer;
  logic issueReady, memWrite, squashNext, busy;
  logic [7:0] memWriteData, workingRegister, tableReadHighByte, ew, et, md;
  logic [5:0] statusFlags, ef;
  logic [31:0] rng = 32'h0001_74C2;
  int failCount = 0, samplesChecked = 0;

  always #10 clk = ~clk;

  mcuex_exec mcuex_exec_inst (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .issueValid(issueValid), .issueReady(issueReady), .issueOp(issueOp),
    .memOperand(memOperand), .literal(literal), .bitIndex(bitIndex), .progWord(progWord),
    .tablePointer(tablePointer), .tablePointerLow(tpLo), .tablePointerHigh(tpHi),
    .memWrite(memWrite), .memWriteData(memWriteData), .workingRegister(workingRegister),
    .statusFlags(statusFlags), .tableReadHighByte(tableReadHighByte),
    .squashNext(squashNext), .busy(busy));

  function automatic logic [31:0] nextRand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Result packed as {write, wdata, work, flags, table_read_high_byte, skip}
  function automatic logic [31:0] model(mcuex_op_t op, logic [7:0] m, l, logic [2:0] bi,
                                        logic [15:0] pw, logic [7:0] w, th, logic [5:0] f);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] s, wd, nw;
    logic [5:0] nf;
    logic b, mw, sk, ov, z;
    mw = 0; wd = 8'h00; nw = w; nf = f; sk = 0;
    s = (op == MCUEX_OP_SUBB_IMM || op == MCUEX_OP_MINUS_IMM) ? l : m;
    b = (op == MCUEX_OP_SUBB_W || op == MCUEX_OP_SUBB_IMM || op == MCUEX_OP_SUBB_MEM) & ~f[0];
    d = {1'b0, w} - {1'b0, s} - b;
    h = {1'b0, w[3:0]} - {1'b0, s[3:0]} - b;
    ov = (w[7] != s[7]) && (d[7] != w[7]);
    z = (d[7:0] == 8'h00);
    case (op)
      MCUEX_OP_ROTR_CARRY_W: begin nw = {f[0], m[7:1]}; nf[0] = m[0]; end
      MCUEX_OP_SUBB_W, MCUEX_OP_SUBB_IMM, MCUEX_OP_MINUS_W, MCUEX_OP_MINUS_IMM: begin
        nw = d[7:0]; nf = {z, ov ^ d[7], ov, z, ~h[4], ~d[8]}; end
      MCUEX_OP_SUBB_MEM, MCUEX_OP_MINUS_MEM: begin
        mw = 1; wd = d[7:0]; nf = {z, ov ^ d[7], ov, z, ~h[4], ~d[8]}; end
      MCUEX_OP_DEC_SKZ: begin mw = 1; wd = m - 8'h01; sk = (m == 8'h01); end
      MCUEX_OP_DEC_SKZ_COPY: begin nw = m - 8'h01; sk = (m == 8'h01); end
      MCUEX_OP_INC_SKZ: begin mw = 1; wd = m + 8'h01; sk = (m == 8'hFF); end
      MCUEX_OP_INC_SKZ_COPY: begin nw = m + 8'h01; sk = (m == 8'hFF); end
      MCUEX_OP_SET_BYTE: begin mw = 1; wd = 8'hFF; end
      MCUEX_OP_SET_BIT: begin mw = 1; wd = m | (8'h01 << bi); end
      MCUEX_OP_SKNZ_BIT: sk = m[bi];
      MCUEX_OP_SKZ_BIT: sk = !m[bi];
      MCUEX_OP_SKNZ_BYTE: begin mw = 1; wd = m; sk = |m; end
      MCUEX_OP_SKZ_BYTE: begin mw = 1; wd = m; sk = ~|m; end
      MCUEX_OP_COPY_SKZ: begin nw = m; sk = ~|m; end
      MCUEX_OP_SWAP_MEM: begin mw = 1; wd = {m[3:0], m[7:4]}; end
      MCUEX_OP_SWAP_W: nw = {m[3:0], m[7:4]};
      MCUEX_OP_TABLE_READ: begin mw = 1; wd = pw[7:0]; th = pw[15:8]; end
      MCUEX_OP_XOR_W: begin nw = w ^ m; nf[2] = ~|nw; end
      MCUEX_OP_XOR_IMM: begin nw = w ^ l; nf[2] = ~|nw; end
      MCUEX_OP_XOR_MEM: begin mw = 1; wd = w ^ m; nf[2] = ~|wd; end
      default: ;
    endcase
    return {mw, wd, nw, nf, th, sk};
  endfunction

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic run(mcuex_op_t op, logic [7:0] m, logic [7:0] l, logic [2:0] bi);
    logic [31:0] e;
    logic [31:0] r;
    @(posedge clk);
    #1;
    r = nextRand();
    issueOp = op;
    memOperand = m;
    literal = l;
    bitIndex = bi;
    issueValid = 1'b1;
    {tpHi, tpLo, progWord} = {r[15:0], r[31:16]};
    e = model(op, m, l, bi, r[31:16], ew, et, ef);
    @(posedge clk);
    #1;
    issueValid = 0;
    check("memWrite", memWrite, e[31]);
    md = e[31] ? e[30:23] : md;
    check("memWriteData", memWriteData, md);
    check("ready", issueReady, !e[0]);
    check("work", workingRegister, e[22:15]);
    check("flags", statusFlags, e[14:9]);
    check("table_read_high_byte", tableReadHighByte, e[8:1]);
    check("squash", squashNext, e[0]);
    check("busy", busy, e[0]);
    check("pointer", tablePointer, {tpHi, tpLo});
    {ew, ef, et} = {e[22:15], e[14:9], e[8:1]};
  endtask

  task automatic stopTest();
    $display("Checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    failCount++;
    stopTest();
  end

  initial begin
    logic [31:0] r;
    {ew, ef, et} = '0;
    md = 8'h00;
    repeat (3) @(posedge clk);
    #1 reset_n = 1;
    // Directed corners: borrow chains, skip boundaries
    run(MCUEX_OP_MINUS_IMM, 8'h00, 8'h01, 3'h0);
    run(MCUEX_OP_SUBB_W, 8'h7F, 8'h00, 3'h0);
    run(MCUEX_OP_SUBB_IMM, 8'h00, 8'h80, 3'h0);
    run(MCUEX_OP_DEC_SKZ, 8'h01, 8'h00, 3'h0);
    run(MCUEX_OP_INC_SKZ_COPY, 8'hFF, 8'h00, 3'h0);
    run(MCUEX_OP_ROTR_CARRY_W, 8'h01, 8'h00, 3'h0);
    run(MCUEX_OP_SKZ_BIT, 8'h7F, 8'h00, 3'h7);
    run(MCUEX_OP_NONE, 8'h5A, 8'hA5, 3'h2);
    for (int i = 0; i < 500; i++) begin
      r = nextRand();
      run(mcuex_op_t'(r[15:0] % 24 + 1), r[25:24] == 0 ? {8{r[26]}} : r[23:16],
          r[7:0], r[30:28]);
    end
    // Frozen clock enable ignores a request
    @(posedge clk);
    #1 clkEn = 1'b0;
    issueOp = MCUEX_OP_SET_BYTE;
    issueValid = 1'b1;
    @(posedge clk);
    #1 clkEn = 1'b1;
    issueValid = 1'b0;
    check("frozen write", memWrite, 1'b0);
    check("frozen work", workingRegister, ew);
    // Request held through a dummy cycle is refused, then taken
    @(posedge clk);
    #1 issueOp = MCUEX_OP_SKZ_BYTE;
    memOperand = 8'h00;
    issueValid = 1'b1;
    @(posedge clk);
    #1 issueOp = MCUEX_OP_SET_BYTE;
    check("skip ready", issueReady, 1'b0);
    @(posedge clk);
    #1 check("refused write", memWrite, 1'b0);
    check("squash once", squashNext, 1'b0);
    @(posedge clk);
    #1 issueValid = 1'b0;
    check("held write", {memWrite, memWriteData}, 9'h1FF);
    // Reset in mid-run, during a dummy cycle, clears state
    @(posedge clk);
    #1 issueOp = MCUEX_OP_SKZ_BIT;
    issueValid = 1'b1;
    @(posedge clk);
    #1 issueValid = 1'b0;
    reset_n = 1'b0;
    check("skip busy", busy, 1'b1);
    @(posedge clk);
    #1 reset_n = 1'b1;
    check("reset work", workingRegister, 8'h00);
    check("reset flags", statusFlags, 6'h00);
    check("reset handshake", {issueReady, busy, squashNext, memWrite}, 4'h8);
    check("reset table_read_high_byte", tableReadHighByte, 8'h00);
    stopTest();
  end
endmodule

`default_nettype wire
